/* File: logic/ddm_calibration_engine.sv */
// Periodic calibration engine for the diagnostic monitor values
`timescale 1ns/1ps
module ddm_calibration_engine #(
  parameter int PERIOD_CYCLES = ddm_cal_pkg::CAL_PERIOD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic convEnable,
  input wire logic loopEnable,
  input wire ddm_cal_pkg::raw_set_t rawIn,
  input wire logic [1:0] mpdRange,
  input wire logic [11:0] rxThreshold,
  input wire logic laserShutdown,
  output ddm_cal_pkg::raw_set_t lutIndex,
  input wire ddm_cal_pkg::flags_t lutFlags,
  input wire ddm_cal_pkg::alarm_mask_t alarm_to_safety_mask,
  output ddm_cal_pkg::flags_t flagsOut,
  output logic alarmFault,
  input wire ddm_cal_pkg::reg_req_t regReq,
  output logic [7:0] regRdata,
  output ddm_cal_pkg::result_set_t resultsOut,
  output logic updateDone
);
  import ddm_cal_pkg::*;

  localparam logic [16:0] PERIOD_LAST = 17'(PERIOD_CYCLES - 1);

  typedef struct packed {
    cal_state_t state;
    logic [16:0] periodCnt;
    raw_set_t snap;
    result_set_t work;
    result_set_t results;
    logic [CFG_BYTES-1:0][7:0] cfgBytes;
    logic [7:0] rdData;
    logic [7:0] snapLow;
    raw_set_t index;
    flags_t flags;
    logic fault;
    logic done;
  } engine_state_t;

  engine_state_t s_reg;
  engine_state_t s_next;

  logic running;
  logic tick;
  logic [11:0] txReranged;
  logic [11:0] rxLinear;
  logic [11:0] calcRaw;
  logic [15:0] calcGain;
  logic [15:0] calcShift;
  logic calcSigned;
  logic [15:0] calcResult;
  logic rxUseHigh;
  raw_set_t rawMasked;
  alarm_mask_t maskedAlarms;

  // ==========================================================================
  // Constant fetch
  function automatic logic [15:0] cfgWord(input logic [CFG_BYTES-1:0][7:0] bytes,
                                          input logic [7:0] ofs);
    cfgWord = {bytes[ofs[4:0]], bytes[ofs[4:0] + 5'd1]};
  endfunction

  // ==========================================================================
  // Operand shaping
  always_comb begin
    case (mpdRange)
      MPD_RANGE_X16: txReranged = {s_reg.snap[M_TX], 4'h0};
      MPD_RANGE_X4: txReranged = {2'b00, s_reg.snap[M_TX], 2'b00};
      default: txReranged = {4'h0, s_reg.snap[M_TX]};
    endcase
  end

  always_comb begin
    logic [11:0] rx;
    rx = {4'h0, s_reg.snap[M_RX]};
    if (rx <= RX_KNEE_LOW) begin
      rxLinear = rx;
    end else if (rx <= RX_KNEE_HIGH) begin
      rxLinear = ((rx - RX_KNEE_LOW) << RX_MID_SHIFT) + RX_KNEE_LOW;
    end else begin
      rxLinear = ((rx - RX_KNEE_HIGH) << RX_HIGH_SHIFT) + RX_HIGH_BASE;
    end
  end

  assign rxUseHigh = rxLinear > rxThreshold;

  always_comb begin
    calcRaw = 12'h000;
    calcGain = 16'h0000;
    calcShift = 16'h0000;
    calcSigned = 1'b0;
    case (s_reg.state)
      ST_TEMP: begin
        calcRaw = {4'h0, s_reg.snap[M_TEMP]};
        calcGain = cfgWord(s_reg.cfgBytes, TEMPERATURE_GAIN_OFS);
        calcShift = cfgWord(s_reg.cfgBytes, TEMPERATURE_SHIFT_OFS);
        calcSigned = 1'b1;
      end
      ST_SUPPLY: begin
        calcRaw = {4'h0, s_reg.snap[M_SUPPLY]};
        calcGain = cfgWord(s_reg.cfgBytes, SUPPLY_GAIN_OFS);
        calcShift = cfgWord(s_reg.cfgBytes, SUPPLY_SHIFT_OFS);
      end
      ST_BIAS: begin
        calcRaw = {4'h0, s_reg.snap[M_BIAS]};
        calcGain = cfgWord(s_reg.cfgBytes, LASER_CURRENT_GAIN_OFS);
        calcShift = cfgWord(s_reg.cfgBytes, LASER_CURRENT_SHIFT_OFS);
      end
      ST_TXPWR: begin
        calcRaw = txReranged;
        calcGain = cfgWord(s_reg.cfgBytes, TX_OPTICAL_GAIN_OFS);
        calcShift = cfgWord(s_reg.cfgBytes, TX_OPTICAL_SHIFT_OFS);
      end
      ST_RXPWR: begin
        calcRaw = rxLinear;
        if (rxUseHigh) begin
          calcGain = cfgWord(s_reg.cfgBytes, RX_OPTICAL_GAIN_HIGH_OFS);
          calcShift = cfgWord(s_reg.cfgBytes, RX_OPTICAL_SHIFT_HIGH_OFS);
        end else begin
          calcGain = cfgWord(s_reg.cfgBytes, RX_OPTICAL_GAIN_LOW_OFS);
          calcShift = cfgWord(s_reg.cfgBytes, RX_OPTICAL_SHIFT_LOW_OFS);
        end
      end
      default: begin
        calcRaw = 12'h000;
      end
    endcase
  end

  // One shared arithmetic unit, one metric per cycle
  cal_arith u_arith (
    .rawValue(calcRaw),
    .gain(calcGain),
    .shift(calcShift),
    .signedOut(calcSigned),
    .result(calcResult)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    rawMasked = rawIn;
    if (laserShutdown) begin
      rawMasked[M_BIAS] = 8'h00;
      rawMasked[M_TX] = 8'h00;
    end
  end

  assign maskedAlarms = {s_reg.flags[4].hiAlarm, s_reg.flags[3].hiAlarm, s_reg.flags[2].hiAlarm,
                         s_reg.flags[1].hiAlarm, s_reg.flags[0].hiAlarm,
                         s_reg.flags[4].loAlarm, s_reg.flags[3].loAlarm, s_reg.flags[2].loAlarm,
                         s_reg.flags[1].loAlarm, s_reg.flags[0].loAlarm}
                        & alarm_to_safety_mask;
  assign running = convEnable & loopEnable;
  assign tick = running && (s_reg.periodCnt == PERIOD_LAST);

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;

    if (!running || tick) begin
      s_next.periodCnt = 17'h00000;
    end else begin
      s_next.periodCnt = s_reg.periodCnt + 17'h00001;
    end

    // A started pass always finishes so the published set stays coherent
    case (s_reg.state)
      ST_IDLE: begin
        if (tick) begin
          s_next.snap = rawMasked;
          s_next.state = ST_TEMP;
        end
      end
      ST_TEMP: begin
        s_next.work[M_TEMP] = calcResult;
        s_next.state = ST_SUPPLY;
      end
      ST_SUPPLY: begin
        s_next.work[M_SUPPLY] = calcResult;
        s_next.state = ST_BIAS;
      end
      ST_BIAS: begin
        s_next.work[M_BIAS] = calcResult;
        s_next.state = ST_TXPWR;
      end
      ST_TXPWR: begin
        s_next.work[M_TX] = calcResult;
        s_next.state = ST_RXPWR;
      end
      ST_RXPWR: begin
        s_next.work[M_RX] = calcResult;
        s_next.state = ST_COMMIT;
      end
      ST_COMMIT: begin
        s_next.results = s_reg.work;
        s_next.done = 1'b1;
        s_next.state = ST_IDLE;
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase

    // Flag lookup follows the raw codes, not the calibrated words
    s_next.index = rawMasked;
    s_next.flags = lutFlags;
    if (laserShutdown) begin
      s_next.flags[M_BIAS].loAlarm = 1'b1;
      s_next.flags[M_BIAS].loWarn = 1'b1;
      s_next.flags[M_TX].loAlarm = 1'b1;
      s_next.flags[M_TX].loWarn = 1'b1;
    end
    s_next.fault = |maskedAlarms;

    // Register port
    if (regReq.write && regReq.space == SPACE_CFG && regReq.addr < 8'(CFG_BYTES)) begin
      s_next.cfgBytes[regReq.addr[4:0]] = regReq.wdata;
    end
    if (regReq.read) begin
      s_next.rdData = UNMAPPED_READ;
      if (regReq.space == SPACE_CFG) begin
        if (regReq.addr < 8'(CFG_BYTES)) begin
          s_next.rdData = s_reg.cfgBytes[regReq.addr[4:0]];
        end
      end else if (regReq.addr >= TEMPERATURE_RESULT_OFS && regReq.addr < RESULT_END_OFS) begin
        // Upper byte read freezes the lower byte for the following read
        if (!regReq.addr[0]) begin
          s_next.rdData = s_reg.results[regReq.addr[3:1]][15:8];
          s_next.snapLow = s_reg.results[regReq.addr[3:1]][7:0];
        end else begin
          s_next.rdData = s_reg.snapLow;
        end
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      for (int m = 0; m < NUM_METRICS; m++) begin
        s_reg.cfgBytes[4*m] <= GAIN_RESET[15:8];
        s_reg.cfgBytes[4*m+1] <= GAIN_RESET[7:0];
        s_reg.cfgBytes[4*m+2] <= SHIFT_RESET[15:8];
        s_reg.cfgBytes[4*m+3] <= SHIFT_RESET[7:0];
      end
      s_reg.cfgBytes[RX_OPTICAL_GAIN_HIGH_OFS[4:0]] <= GAIN_RESET[15:8];
      s_reg.cfgBytes[RX_OPTICAL_GAIN_HIGH_OFS[4:0] + 5'd1] <= GAIN_RESET[7:0];
      s_reg.results <= {NUM_METRICS{RESULT_RESET}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign lutIndex = s_reg.index;
  assign flagsOut = s_reg.flags;
  assign alarmFault = s_reg.fault;
  assign regRdata = s_reg.rdData;
  assign resultsOut = s_reg.results;
  assign updateDone = s_reg.done;

  // ==========================================================================
  // Assertions
  property p_start_on_period;
    @(posedge clk_sys) disable iff (srst)
    (s_reg.state == ST_IDLE && s_next.state == ST_TEMP) |->
      (s_reg.periodCnt == PERIOD_LAST && convEnable && loopEnable);
  endproperty
  a_start_on_period: assert property (p_start_on_period)
    else $error("Calibration pass started off the period boundary");

  property p_pass_length;
    @(posedge clk_sys) disable iff (srst)
    (s_reg.state == ST_TEMP) |-> ##6 (s_reg.state == ST_IDLE && updateDone);
  endproperty
  a_pass_length: assert property (p_pass_length)
    else $error("Calibration pass did not finish in six cycles");

  property p_commit_publishes;
    @(posedge clk_sys) disable iff (srst)
    (s_reg.state == ST_COMMIT) |=> (resultsOut == $past(s_reg.work));
  endproperty
  a_commit_publishes: assert property (p_commit_publishes)
    else $error("Results not published from the finished pass");

  property p_results_stable;
    @(posedge clk_sys) disable iff (srst)
    (s_reg.state != ST_COMMIT) |=> $stable(resultsOut);
  endproperty
  a_results_stable: assert property (p_results_stable)
    else $error("Results changed outside the commit cycle");

  property p_temp_word_order;
    @(posedge clk_sys) disable iff (srst)
    (s_reg.state == ST_TEMP) |-> (calcGain == {s_reg.cfgBytes[0], s_reg.cfgBytes[1]});
  endproperty
  a_temp_word_order: assert property (p_temp_word_order)
    else $error("Temperature slope byte order wrong");

  property p_tx_rerange;
    @(posedge clk_sys) disable iff (srst)
    (s_reg.state == ST_TXPWR && mpdRange == MPD_RANGE_X16) |->
      (calcRaw == {s_reg.snap[M_TX], 4'h0});
  endproperty
  a_tx_rerange: assert property (p_tx_rerange)
    else $error("Tx power not scaled by sixteen");

  property p_rx_high_segment;
    @(posedge clk_sys) disable iff (srst)
    (s_reg.state == ST_RXPWR && s_reg.snap[M_RX] > 8'h80) |->
      (calcRaw == 12'(({4'h0, s_reg.snap[M_RX]} - 12'h080) * 16 + 12'h1a0));
  endproperty
  a_rx_high_segment: assert property (p_rx_high_segment)
    else $error("Receive code linearized wrongly in top segment");

  property p_rx_pair_select;
    @(posedge clk_sys) disable iff (srst)
    (s_reg.state == ST_RXPWR && calcRaw > rxThreshold) |->
      (calcGain == {s_reg.cfgBytes[20], s_reg.cfgBytes[21]});
  endproperty
  a_rx_pair_select: assert property (p_rx_pair_select)
    else $error("High receive pair not selected above threshold");

  property p_shutdown_flags;
    @(posedge clk_sys) disable iff (srst)
    laserShutdown |=> (flagsOut[M_BIAS].loAlarm && flagsOut[M_TX].loWarn
                       && lutIndex[M_BIAS] == 8'h00 && lutIndex[M_TX] == 8'h00);
  endproperty
  a_shutdown_flags: assert property (p_shutdown_flags)
    else $error("Shutdown did not zero readings and set low flags");

  property p_mask_blocks;
    @(posedge clk_sys) disable iff (srst)
    (alarm_to_safety_mask == '0) |=> !alarmFault;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("Masked alarms raised the safety fault");

endmodule

/* File: include/ddm_cal_pkg.sv */
// Package: register map, timing, state and carrier types of the calibration engine
package ddm_cal_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CAL_PERIOD_MS = 10;
  localparam int CAL_PERIOD_CYCLES = CAL_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  // ==========================================================================
  // Metric indices
  localparam int M_TEMP = 0;
  localparam int M_SUPPLY = 1;
  localparam int M_BIAS = 2;
  localparam int M_TX = 3;
  localparam int M_RX = 4;
  localparam int NUM_METRICS = 5;

  // ==========================================================================
  // Configuration space (constants, MSB at the lower address)
  localparam logic [7:0] TEMPERATURE_GAIN_OFS = 8'h00;
  localparam logic [7:0] TEMPERATURE_SHIFT_OFS = 8'h02;
  localparam logic [7:0] SUPPLY_GAIN_OFS = 8'h04;
  localparam logic [7:0] SUPPLY_SHIFT_OFS = 8'h06;
  localparam logic [7:0] LASER_CURRENT_GAIN_OFS = 8'h08;
  localparam logic [7:0] LASER_CURRENT_SHIFT_OFS = 8'h0a;
  localparam logic [7:0] TX_OPTICAL_GAIN_OFS = 8'h0c;
  localparam logic [7:0] TX_OPTICAL_SHIFT_OFS = 8'h0e;
  localparam logic [7:0] RX_OPTICAL_GAIN_LOW_OFS = 8'h10;
  localparam logic [7:0] RX_OPTICAL_SHIFT_LOW_OFS = 8'h12;
  localparam logic [7:0] RX_OPTICAL_GAIN_HIGH_OFS = 8'h14;
  localparam logic [7:0] RX_OPTICAL_SHIFT_HIGH_OFS = 8'h16;
  localparam int CFG_BYTES = 24;

  // Diagnostic space (results)
  localparam logic [7:0] TEMPERATURE_RESULT_OFS = 8'h60;
  localparam logic [7:0] SUPPLY_RESULT_OFS = 8'h62;
  localparam logic [7:0] LASER_CURRENT_RESULT_OFS = 8'h64;
  localparam logic [7:0] TX_OPTICAL_RESULT_OFS = 8'h66;
  localparam logic [7:0] RX_OPTICAL_RESULT_OFS = 8'h68;
  localparam logic [7:0] RESULT_END_OFS = 8'h6a;

  localparam logic SPACE_DIAG = 1'b0;
  localparam logic SPACE_CFG = 1'b1;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] GAIN_RESET = 16'h0100;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================================
  // Arithmetic
  localparam int GAIN_FRAC_BITS = 8;
  localparam logic [1:0] MPD_RANGE_X16 = 2'b10;
  localparam logic [1:0] MPD_RANGE_X4 = 2'b01;
  localparam int TX_SHIFT_X16 = 4;
  localparam int TX_SHIFT_X4 = 2;
  localparam logic [11:0] RX_KNEE_LOW = 12'h020;
  localparam logic [11:0] RX_KNEE_HIGH = 12'h080;
  localparam logic [11:0] RX_HIGH_BASE = 12'h1a0;
  localparam int RX_MID_SHIFT = 2;
  localparam int RX_HIGH_SHIFT = 4;
  localparam logic signed [21:0] SAT_SIGNED_MAX = 22'sh007fff;
  localparam logic signed [21:0] SAT_SIGNED_MIN = -22'sh008000;
  localparam logic signed [21:0] SAT_UNSIGNED_MAX = 22'sh00ffff;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TEMP = 3'b001,
    ST_SUPPLY = 3'b011,
    ST_BIAS = 3'b010,
    ST_TXPWR = 3'b110,
    ST_RXPWR = 3'b111,
    ST_COMMIT = 3'b101
  } cal_state_t;

  typedef logic [NUM_METRICS-1:0][7:0] raw_set_t;
  typedef logic [NUM_METRICS-1:0][15:0] result_set_t;

  typedef struct packed {
    logic hiAlarm;
    logic loAlarm;
    logic hiWarn;
    logic loWarn;
  } flag_set_t;

  typedef flag_set_t [NUM_METRICS-1:0] flags_t;

  typedef struct packed {
    logic [NUM_METRICS-1:0] hiAlarm;
    logic [NUM_METRICS-1:0] loAlarm;
  } alarm_mask_t;

  typedef struct packed {
    logic write;
    logic read;
    logic space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

/* File: logic/cal_arith.sv */
// Slope/offset arithmetic with saturation, shared by all metrics
`timescale 1ns/1ps
module cal_arith (
  input wire logic [11:0] rawValue,
  input wire logic [15:0] gain,
  input wire logic [15:0] shift,
  input wire logic signedOut,
  output logic [15:0] result
);
  import ddm_cal_pkg::*;

  logic [27:0] product;
  logic [19:0] scaled;
  logic signed [21:0] sum;

  assign product = rawValue * gain;
  assign scaled = product[27:GAIN_FRAC_BITS];
  assign sum = $signed({2'b00, scaled}) + $signed({{6{shift[15]}}, shift});

  // Clamp instead of wrapping so a large reading never shows as a tiny one
  always_comb begin
    result = sum[15:0];
    if (signedOut) begin
      if (sum > SAT_SIGNED_MAX) begin
        result = SAT_SIGNED_MAX[15:0];
      end else if (sum < SAT_SIGNED_MIN) begin
        result = SAT_SIGNED_MIN[15:0];
      end
    end else begin
      if (sum < 0) begin
        result = 16'h0000;
      end else if (sum > SAT_UNSIGNED_MAX) begin
        result = SAT_UNSIGNED_MAX[15:0];
      end
    end
  end

endmodule

/* File: testbench/ddm_host_model.sv */
// Host on the byte register port plus the alarm and warning table
`timescale 1ns/1ps
module ddm_host_model (
  input wire logic clk_sys,
  output ddm_cal_pkg::reg_req_t regReq,
  input wire logic [7:0] regRdata,
  input wire ddm_cal_pkg::raw_set_t lutIndex,
  output ddm_cal_pkg::flags_t lutFlags
);
  import ddm_cal_pkg::*;

  // ==========================================================================
  // Alarm table
  // Contents are arbitrary, but every index bit moves some flag
  always_comb begin
    for (int i = 0; i < NUM_METRICS; i++) begin
      lutFlags[i] = lutIndex[i][7:4] ^ lutIndex[i][3:0];
    end
  end

  // ==========================================================================
  // Register access
  initial regReq = '0;

  // One-cycle strobe; read data is valid when the task returns
  task automatic put(input logic sp, input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_sys);
    regReq = '{write: w, read: !w, space: sp, addr: a, wdata: d};
    @(negedge clk_sys);
    regReq = '0;
  endtask
endmodule

/* File: testbench/test_ddm_calibration_engine.sv */
// Self-checking testbench of the calibration engine
`timescale 1ns/1ps
module test_ddm_calibration_engine;
  import ddm_cal_pkg::*;

  // Short period keeps the run brief; all expectations use it
  localparam int P = 20;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic convEnable = 1'b0;
  logic loopEnable = 1'b0;
  raw_set_t rawIn = '0;
  logic [1:0] mpdRange = 2'b00;
  logic [11:0] rxThreshold = '0;
  logic laserShutdown = 1'b0;
  alarm_mask_t safetyMask = '0;
  raw_set_t lutIndex;
  flags_t lutFlags;
  flags_t flagsOut;
  logic alarmFault;
  logic updateDone;
  reg_req_t regReq;
  logic [7:0] regRdata;
  result_set_t resultsOut;
  logic [15:0] cfg [12];
  logic [15:0] w;
  integer seed = 72;
  int failures = 0;
  int comparisons = 0;
  int n;

  always #50 clk_sys = ~clk_sys;

  ddm_calibration_engine #(.PERIOD_CYCLES(P)) i_ddm_calibration_engine (
    .clk_sys(clk_sys), .srst(srst), .convEnable(convEnable), .loopEnable(loopEnable),
    .rawIn(rawIn), .mpdRange(mpdRange), .rxThreshold(rxThreshold),
    .laserShutdown(laserShutdown), .lutIndex(lutIndex), .lutFlags(lutFlags),
    .alarm_to_safety_mask(safetyMask), .flagsOut(flagsOut), .alarmFault(alarmFault),
    .regReq(regReq), .regRdata(regRdata), .resultsOut(resultsOut), .updateDone(updateDone)
  );

  ddm_host_model i_ddm_host_model (
    .clk_sys(clk_sys), .regReq(regReq), .regRdata(regRdata),
    .lutIndex(lutIndex), .lutFlags(lutFlags)
  );

  // ==========================================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    i_ddm_host_model.put(SPACE_CFG, a, v[15:8], 1'b1);
    i_ddm_host_model.put(SPACE_CFG, a + 8'h01, v[7:0], 1'b1);
  endtask

  task automatic rd16(input logic sp, input logic [7:0] a, output logic [15:0] v);
    i_ddm_host_model.put(sp, a, 8'h00, 1'b0);
    v[15:8] = regRdata;
    i_ddm_host_model.put(sp, a + 8'h01, 8'h00, 1'b0);
    v[7:0] = regRdata;
  endtask

  task automatic wait_done(output int cnt);
    cnt = 0;
    while (updateDone !== 1'b1 && cnt < 4 * P) begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask

  function automatic logic [15:0] cal(input int r, input logic [15:0] g,
                                      input logic [15:0] s, input bit sgn);
    longint v;
    v = (longint'(r) * longint'(g)) >> 8;
    v = v + longint'($signed(s));
    if (sgn) begin
      v = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    end else begin
      v = v > 65535 ? 65535 : (v < 0 ? 0 : v);
    end
    return v[15:0];
  endfunction

  function automatic bit cut(input int m);
    return laserShutdown && (m == M_BIAS || m == M_TX);
  endfunction

  function automatic int eff(input int m);
    int c;
    c = cut(m) ? 0 : int'(rawIn[m]);
    if (m == M_TX) begin
      c = mpdRange == 2'b10 ? c << 4 : (mpdRange == 2'b01 ? c << 2 : c);
    end
    if (m == M_RX) begin
      c = c <= 32 ? c : (c <= 128 ? (c - 32) * 4 + 32 : (c - 128) * 16 + 416);
    end
    return c;
  endfunction

  task automatic flags_check;
    flag_set_t f;
    logic [7:0] ix;
    logic fault;
    fault = 1'b0;
    repeat (3) @(negedge clk_sys);
    for (int m = 0; m < NUM_METRICS; m++) begin
      ix = cut(m) ? 8'h00 : rawIn[m];
      f = ix[7:4] ^ ix[3:0];
      if (cut(m)) begin
        f.loAlarm = 1'b1;
        f.loWarn = 1'b1;
      end
      fault = fault | (f.hiAlarm & safetyMask.hiAlarm[m]) | (f.loAlarm & safetyMask.loAlarm[m]);
      check(16'(lutIndex[m]), 16'(ix));
      check(16'(flagsOut[m]), 16'(f));
    end
    check(16'(alarmFault), 16'(fault));
  endtask

  // ==========================================================================
  // One calibration pass with corner or random inputs
  task automatic pass_check(input int i);
    int k;
    logic [15:0] x;
    int rxc [6] = '{32, 33, 128, 129, 255, 0};
    for (int c = 0; c < 12; c++) begin
      cfg[c] = i == 0 ? (c[0] ? 16'h7fff : 16'hffff) : 16'($random(seed));
      cfg[c] = i == 1 ? (c[0] ? 16'h8000 : 16'h0000) : cfg[c];
      wr16(8'(2 * c), cfg[c]);
    end
    for (int c = 0; c < 12; c++) begin
      rd16(SPACE_CFG, 8'(2 * c), w);
      check(w, cfg[c]);
    end
    @(negedge clk_sys);
    for (int m = 0; m < NUM_METRICS; m++) begin
      rawIn[m] = 8'($random(seed));
    end
    rawIn[M_RX] = i < 6 ? 8'(rxc[i]) : rawIn[M_RX];
    laserShutdown = i == 3 || i == 7;
    mpdRange = 2'(i);
    safetyMask = alarm_mask_t'($random(seed));
    rxThreshold = i == 2 ? 12'(eff(M_RX)) : 12'($random(seed));
    convEnable = 1'b1;
    loopEnable = 1'b1;
    wait_done(n);
    check(16'(n), 16'(P + 6));
    for (int m = 0; m < NUM_METRICS; m++) begin
      k = m < M_RX ? m : (eff(M_RX) > rxThreshold ? 5 : 4);
      x = cal(eff(m), cfg[2 * k], cfg[2 * k + 1], m == M_TEMP);
      check(resultsOut[m], x);
      rd16(SPACE_DIAG, 8'h60 + 8'(2 * m), w);
      check(w, x);
    end
    flags_check;
    convEnable = 1'b0;
    loopEnable = 1'b0;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    for (int c = 0; c < 12; c++) begin
      rd16(SPACE_CFG, 8'(2 * c), w);
      check(w, c[0] ? SHIFT_RESET : GAIN_RESET);
    end
    i_ddm_host_model.put(SPACE_CFG, 8'h18, 8'h5a, 1'b1);
    i_ddm_host_model.put(SPACE_DIAG, 8'h60, 8'ha5, 1'b1);
    rd16(SPACE_CFG, 8'h18, w);
    check(w, {UNMAPPED_READ, UNMAPPED_READ});
    rd16(SPACE_DIAG, 8'h60, w);
    check(w, RESULT_RESET);
    $display("test reset and refused writes done");
    for (int i = 0; i < 10; i++) begin
      pass_check(i);
    end
    $display("test calibration passes done");
    @(negedge clk_sys);
    convEnable = 1'b1;
    loopEnable = 1'b1;
    wait_done(n);
    @(negedge clk_sys);
    wait_done(n);
    check(16'(n + 1), 16'(P));
    for (int e = 0; e < 2; e++) begin
      @(negedge clk_sys);
      convEnable = e[0];
      loopEnable = !e[0];
      wait_done(n);
      check(16'(n), 16'(4 * P));
    end
    $display("test cadence and enables done");
    // A commit between the two byte reads must not tear the word
    wr16(TEMPERATURE_GAIN_OFS, GAIN_RESET);
    wr16(TEMPERATURE_SHIFT_OFS, SHIFT_RESET);
    rawIn[M_TEMP] = 8'h5a;
    convEnable = 1'b1;
    loopEnable = 1'b1;
    wait_done(n);
    rawIn[M_TEMP] = 8'ha5;
    i_ddm_host_model.put(SPACE_DIAG, TEMPERATURE_RESULT_OFS, 8'h00, 1'b0);
    w[15:8] = regRdata;
    wait_done(n);
    i_ddm_host_model.put(SPACE_DIAG, TEMPERATURE_RESULT_OFS + 8'h01, 8'h00, 1'b0);
    w[7:0] = regRdata;
    check(w, cal(32'h5a, GAIN_RESET, SHIFT_RESET, 1'b1));
    check(resultsOut[M_TEMP], cal(32'ha5, GAIN_RESET, SHIFT_RESET, 1'b1));
    $display("test split read across commit done");
    complete_run;
  end

  initial begin
    #2000000;
    failures++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    complete_run;
  end
endmodule
